/* File: inc/pit_pkg.sv */
package pit_pkg;
  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] PIT_OFS_COUNT  = 8'h00;
  localparam logic [7:0] PIT_OFS_SCALE  = 8'h04;
  localparam logic [7:0] PIT_OFS_PERIOD = 8'h08;
  localparam logic [7:0] PIT_OFS_CTRL   = 8'h0c;
  localparam logic [7:0] PIT_OFS_STAT   = 8'h10;
  localparam logic [7:0] PIT_OFS_CLEAR  = 8'h14;
  localparam logic [7:0] PIT_OFS_IRQEN  = 8'h18;

  // ==========================================================================
  // Field layout and widths.
  localparam int PIT_COUNT_W  = 16;
  localparam int PIT_SCALE_W  = 8;
  localparam int PIT_CTRL_RUN = 0;
  localparam int PIT_EVT_ZERO = 0;
  localparam int PIT_EVT_W    = 1;

  // ==========================================================================
  // Reset values and the constant one at 8 and 16 bits.
  localparam logic [15:0] PIT_RST_COUNT  = 16'h0000;
  localparam logic [15:0] PIT_RST_PERIOD = 16'h0000;
  localparam logic [7:0]  PIT_RST_SCALE  = 8'h00;
  localparam logic [7:0]  PIT_ONE8       = 8'h01;
  localparam logic [15:0] PIT_ONE16      = 16'h0001;
endpackage : pit_pkg

/* File: src/pit_timer.sv */
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Count drops by one every n cycles.
// - Prescale n held in 8-bit writable register.
// - Zero count raises the timer interrupt.
// - Zero count reloads from 16-bit period.
module pit_timer
  import pit_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  output logic                   irq
);

  // ==========================================================================
  // State.
  logic [PIT_COUNT_W-1:0] timer_down_count;
  logic [PIT_SCALE_W-1:0] timer_cycle_prescale;
  logic [PIT_COUNT_W-1:0] timer_reload_period;
  logic                   run;
  logic [PIT_SCALE_W-1:0] pre_cnt;
  logic [PIT_EVT_W-1:0]   irq_stat;
  logic [PIT_EVT_W-1:0]   irq_en;

  logic [PIT_COUNT_W-1:0] next_timer_down_count;
  logic [PIT_SCALE_W-1:0] next_timer_cycle_prescale;
  logic [PIT_COUNT_W-1:0] next_timer_reload_period;
  logic                   next_run;
  logic [PIT_SCALE_W-1:0] next_pre_cnt;
  logic [PIT_EVT_W-1:0]   next_irq_stat;
  logic [PIT_EVT_W-1:0]   next_irq_en;
  logic                   next_pready;
  logic [31:0]            next_prdata;
  logic                   next_pslverr;
  logic                   next_irq;

  logic [ADDR_W-1:0] ofs;
  logic              wr;
  logic              tick;
  logic              hit_zero;

  // A prescale of zero is treated as one, so the counter never stalls.
  function automatic logic [PIT_SCALE_W-1:0] eff_scale(input logic [PIT_SCALE_W-1:0] s);
    eff_scale = (s == '0) ? PIT_ONE8 : s;
  endfunction : eff_scale

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == ADDR_W'(PIT_OFS_COUNT)) || (a == ADDR_W'(PIT_OFS_SCALE)) ||
             (a == ADDR_W'(PIT_OFS_PERIOD)) || (a == ADDR_W'(PIT_OFS_CTRL)) ||
             (a == ADDR_W'(PIT_OFS_STAT)) || (a == ADDR_W'(PIT_OFS_CLEAR)) ||
             (a == ADDR_W'(PIT_OFS_IRQEN));
  endfunction : mapped

  assign ofs      = paddr;
  assign wr       = psel && penable && pready && pwrite;
  assign tick     = run && (pre_cnt >= eff_scale(timer_cycle_prescale) - PIT_ONE8);
  assign hit_zero = tick && (timer_down_count == '0);

  // ==========================================================================
  // Next-state logic.
  always_comb begin
    next_timer_down_count     = timer_down_count;
    next_timer_cycle_prescale = timer_cycle_prescale;
    next_timer_reload_period  = timer_reload_period;
    next_run                  = run;
    next_pre_cnt              = pre_cnt;
    next_irq_stat             = irq_stat;
    next_irq_en               = irq_en;

    if (run) begin
      next_pre_cnt = tick ? '0 : pre_cnt + PIT_ONE8;
    end
    if (hit_zero) begin
      next_timer_down_count = timer_reload_period;
      next_pre_cnt          = '0;
    end else if (tick) begin
      next_timer_down_count = timer_down_count - PIT_ONE16;
    end

    if (wr) begin
      if (ofs == ADDR_W'(PIT_OFS_COUNT)) begin
        next_timer_down_count = pwdata[PIT_COUNT_W-1:0];
        next_pre_cnt          = '0;
      end
      if (ofs == ADDR_W'(PIT_OFS_SCALE)) begin
        next_timer_cycle_prescale = pwdata[PIT_SCALE_W-1:0];
      end
      if (ofs == ADDR_W'(PIT_OFS_PERIOD)) begin
        next_timer_reload_period = pwdata[PIT_COUNT_W-1:0];
      end
      if (ofs == ADDR_W'(PIT_OFS_CTRL)) begin
        next_run = pwdata[PIT_CTRL_RUN];
      end
      if (ofs == ADDR_W'(PIT_OFS_CLEAR)) begin
        next_irq_stat = irq_stat & ~pwdata[PIT_EVT_W-1:0];
      end
      if (ofs == ADDR_W'(PIT_OFS_IRQEN)) begin
        next_irq_en = pwdata[PIT_EVT_W-1:0];
      end
    end
    // The zero event is applied last so it wins over a clear in the same cycle.
    if (hit_zero) begin
      next_irq_stat[PIT_EVT_ZERO] = 1'b1;
    end
    next_irq = |(next_irq_stat & next_irq_en);
  end

  // The slave answers in the first access cycle with no wait state, with read data registered in the setup phase.
  always_comb begin
    next_pready  = psel && !penable;
    next_prdata  = '0;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_pslverr = !mapped(ofs);
      if (!pwrite) begin
        case (ofs)
          ADDR_W'(PIT_OFS_COUNT):  next_prdata = 32'(timer_down_count);
          ADDR_W'(PIT_OFS_SCALE):  next_prdata = 32'(timer_cycle_prescale);
          ADDR_W'(PIT_OFS_PERIOD): next_prdata = 32'(timer_reload_period);
          ADDR_W'(PIT_OFS_CTRL):   next_prdata = 32'(run);
          ADDR_W'(PIT_OFS_STAT):   next_prdata = 32'(irq_stat);
          ADDR_W'(PIT_OFS_IRQEN):  next_prdata = 32'(irq_en);
          default:                 next_prdata = '0;
        endcase
      end
    end
  end

  // ==========================================================================
  // Registers.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      timer_down_count     <= PIT_RST_COUNT;
      timer_cycle_prescale <= PIT_RST_SCALE;
      timer_reload_period  <= PIT_RST_PERIOD;
      run                  <= 1'b0;
      pre_cnt              <= '0;
      irq_stat             <= '0;
      irq_en               <= '0;
      pready               <= 1'b0;
      prdata               <= '0;
      pslverr              <= 1'b0;
      irq                  <= 1'b0;
    end else begin
      timer_down_count     <= next_timer_down_count;
      timer_cycle_prescale <= next_timer_cycle_prescale;
      timer_reload_period  <= next_timer_reload_period;
      run                  <= next_run;
      pre_cnt              <= next_pre_cnt;
      irq_stat             <= next_irq_stat;
      irq_en               <= next_irq_en;
      pready               <= next_pready;
      prdata               <= next_prdata;
      pslverr              <= next_pslverr;
      irq                  <= next_irq;
    end
  end

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  logic                   wr_count;
  logic                   wr_scale;
  logic [PIT_SCALE_W-1:0] gap_cnt;
  logic [PIT_SCALE_W-1:0] next_gap_cnt;
  logic                   gap_ok;
  logic                   next_gap_ok;

  assign wr_count = wr && (ofs == ADDR_W'(PIT_OFS_COUNT));
  assign wr_scale = wr && (ofs == ADDR_W'(PIT_OFS_SCALE));

  // Counts the cycles since the last tick for the spacing check. The gap is a full
  // prescale period only while the timer ran with no prescale write or count load.
  always_comb begin
    next_gap_cnt = tick ? '0 : gap_cnt + PIT_ONE8;
    next_gap_ok  = gap_ok || tick;
    if (!run || wr_scale || wr_count) begin
      next_gap_ok = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      gap_cnt <= '0;
      gap_ok  <= 1'b0;
    end else begin
      gap_cnt <= next_gap_cnt;
      gap_ok  <= next_gap_ok;
    end
  end

  sequence s_zero_tick;
    hit_zero && !wr_count;
  endsequence

  sequence s_step_tick;
    tick && (timer_down_count != '0) && !wr_count;
  endsequence

  a_count_step: assert property (
    s_step_tick |=> timer_down_count == $past(timer_down_count) - PIT_ONE16)
    else $error("count did not drop by one");
  a_count_hold: assert property (
    (!tick && !wr_count) |=> $stable(timer_down_count))
    else $error("count moved without a tick");
  a_tick_spacing: assert property (
    (tick && gap_ok) |-> gap_cnt == eff_scale(timer_cycle_prescale) - PIT_ONE8)
    else $error("tick spacing broken");
  a_scale_write: assert property (
    wr_scale |=> timer_cycle_prescale == $past(pwdata[PIT_SCALE_W-1:0]))
    else $error("prescale not stored");
  a_zero_flag: assert property (
    s_zero_tick |=> irq_stat[PIT_EVT_ZERO])
    else $error("zero event not flagged");
  a_zero_irq: assert property (
    (s_zero_tick ##0 (irq_en[PIT_EVT_ZERO] && !wr)) |=> irq)
    else $error("irq not raised");
  a_zero_reload: assert property (
    s_zero_tick |=> timer_down_count == $past(timer_reload_period))
    else $error("period not reloaded");
  a_reload_restart: assert property (
    s_zero_tick |=> pre_cnt == '0 ##1 (!run || pre_cnt <= PIT_ONE8))
    else $error("prescale not restarted");
  a_apb_answer: assert property (
    (psel && !penable) |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

endmodule : pit_timer

/* File: dv/pit_timer_tb_top.sv */
`timescale 1ns/1ps
module pit_timer_tb_top;
  import pit_pkg::*;
  // ==========================================================================
  // Stimulus and observation signals.
  logic        sys_clk = 1'b0;
  logic        reset   = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        er;
  int          errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          t1;
  int          t2;
  int          sc[3] = '{1, 3, 0};
  int          pr[3] = '{5, 2, 4};
  // Divisor in effect for each prescale setting; a prescale of zero divides by one.
  int          eff[3] = '{1, 3, 1};
  logic [7:0]  ofs[3] = '{PIT_OFS_COUNT, PIT_OFS_SCALE, PIT_OFS_PERIOD};

  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  pit_timer dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .irq(irq));

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer: the request stands until pready is seen high at a rising edge,
  // the answer is taken at that edge and only then is the request released.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Waits for a fresh rise of the interrupt and returns the cycle number seen.
  // Only the watchdog ends a wait that never finishes.
  task automatic wait_irq(output int t);
    while (irq !== 1'b0) @(negedge sys_clk);
    while (irq !== 1'b1) @(negedge sys_clk);
    t = cyc;
  endtask : wait_irq

  task automatic wrap_up;
    $display("Checks made: %0d, mismatches: %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  initial begin
    #(50 * 20000);
    errors++;
    wrap_up();
  end

  // ==========================================================================
  // Test sequence.
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, 32'h0);
    end
    chk({31'h0, er}, 32'h0);
    apb(1'b1, PIT_OFS_SCALE, 32'h1c8);
    apb(1'b0, PIT_OFS_SCALE, 32'h0);
    chk(rd, 32'hc8);
    apb(1'b1, PIT_OFS_PERIOD, 32'h10100);
    apb(1'b0, PIT_OFS_PERIOD, 32'h0);
    chk(rd, 32'h0100);
    apb(1'b1, PIT_OFS_CTRL, 32'h1);
    apb(1'b1, PIT_OFS_COUNT, 32'h12350);
    apb(1'b0, PIT_OFS_COUNT, 32'h0);
    chk(rd, 32'h2350);
    repeat (500) @(posedge sys_clk);
    apb(1'b0, PIT_OFS_COUNT, 32'h0);
    chk(rd, 32'h234e);
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, PIT_OFS_CTRL, 32'h0);
      apb(1'b1, PIT_OFS_SCALE, 32'(sc[i]));
      apb(1'b1, PIT_OFS_PERIOD, 32'(pr[i]));
      apb(1'b1, PIT_OFS_COUNT, 32'h0);
      apb(1'b1, PIT_OFS_IRQEN, 32'h1);
      apb(1'b1, PIT_OFS_CLEAR, 32'h1);
      apb(1'b1, PIT_OFS_CTRL, 32'h1);
      wait_irq(t1);
      apb(1'b1, PIT_OFS_CLEAR, 32'h1);
      wait_irq(t2);
      chk(32'(t2 - t1), 32'((pr[i] + 1) * eff[i]));
    end
    apb(1'b1, PIT_OFS_IRQEN, 32'h0);
    repeat (20) @(posedge sys_clk);
    apb(1'b0, PIT_OFS_STAT, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, PIT_OFS_CTRL, 32'h0);
    apb(1'b1, PIT_OFS_CLEAR, 32'h1);
    apb(1'b0, PIT_OFS_STAT, 32'h0);
    chk(rd, 32'h0);
    wrap_up();
  end
endmodule : pit_timer_tb_top
